// >>> lmc_params.svh
// Purpose: Offsets, field positions and reset values of the link mode bank
// Assumes: Included by bare name from design files
// Notes:   Definitions only
`ifndef LMC_PARAMS_SVH
`define LMC_PARAMS_SVH

// ----------------------------------------------------------------
// Address map, offsets within one link page
// ----------------------------------------------------------------
`define LMC_OFS_SYS 8'h01
`define LMC_OFS_MODE 8'h20
`define LMC_OFS_CTRL 8'h21
`define LMC_OFS_TERM 8'h32
`define LMC_OFS_EVT 8'h38
`define LMC_NUM_LINKS 8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LMC_MODE_FF_LSB 0
`define LMC_MODE_JV_BIT 2
`define LMC_MODE_CF_BIT 3
`define LMC_CTRL_AMI_BIT 0
`define LMC_CTRL_BPV_BIT 1
`define LMC_CTRL_UNFR_BIT 2
`define LMC_CTRL_RATE_BIT 3
`define LMC_CTRL_MUX_BIT 4
`define LMC_TERM_EXT_BIT 2
`define LMC_SYS_E1GRP_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LMC_RST_MODE 8'h00
`define LMC_RST_CTRL 8'h00
`define LMC_RST_TERM 8'h00
`define LMC_RST_SYS 8'h00
`define LMC_RST_EVT 3'h0

`endif

// >>> lmc_pkg.sv
// Purpose: Types shared by the link mode bank
// Assumes: Nothing
// Notes:   Constants live in lmc_params.svh
package lmc_pkg;
    typedef enum logic [2:0] {
        LMC_FMT_T1_SF,
        LMC_FMT_T1_ESF,
        LMC_FMT_T1_DM,
        LMC_FMT_T1_SLC96,
        LMC_FMT_J1_SF,
        LMC_FMT_J1_ESF,
        LMC_FMT_E1,
        LMC_FMT_RESERVED
    } lmc_fmt_e;

    typedef enum logic [1:0] {
        LMC_CODE_AMI,
        LMC_CODE_B8ZS,
        LMC_CODE_HDB3
    } lmc_code_e;
endpackage

// >>> lmc_link_if.sv
// Purpose: Carries one link's settings to its decoder and the results back
// Assumes: One instance per link
// Notes:   cfg side owns the registers
`timescale 1ns/10ps
`default_nettype none
interface lmc_link_if;
    import lmc_pkg::*;
    logic [7:0] mode;
    logic [7:0] ctrl;
    logic [7:0] term;
    lmc_fmt_e fmt;
    logic reserved;
    logic unframed;
    logic int_term_en;
    logic [1:0] term_sel;
    lmc_code_e rx_code;
    lmc_code_e tx_code;
    logic bpv_en;
    logic rate_conv;
    logic [1:0] hdlc_cnt;
    modport cfg (output mode, ctrl, term, input fmt, reserved, unframed, int_term_en, term_sel,
        rx_code, tx_code, bpv_en, rate_conv, hdlc_cnt);
    modport dec (input mode, ctrl, term, output fmt, reserved, unframed, int_term_en, term_sel,
        rx_code, tx_code, bpv_en, rate_conv, hdlc_cnt);
endinterface
`default_nettype wire

// >>> lmc_mode_decode.sv
// Purpose: Turns one link's register contents into its operating personality
// Assumes: Register values are stable flops in the bank
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
`include "lmc_params.svh"
module lmc_mode_decode
    import lmc_pkg::*;
(
    // Link settings and results
    lmc_link_if.dec lnk
);
    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    function automatic lmc_fmt_e decode_fmt(input logic [7:0] m);
        logic [1:0] ff;
        ff = m[`LMC_MODE_FF_LSB +: 2];
        if (!m[`LMC_MODE_CF_BIT]) begin
            decode_fmt = LMC_FMT_E1;
        end else if (!m[`LMC_MODE_JV_BIT]) begin
            case (ff)
                2'h0: decode_fmt = LMC_FMT_T1_SF;
                2'h1: decode_fmt = LMC_FMT_T1_ESF;
                2'h2: decode_fmt = LMC_FMT_T1_DM;
                default: decode_fmt = LMC_FMT_T1_SLC96;
            endcase
        end else begin
            case (ff)
                2'h0: decode_fmt = LMC_FMT_J1_SF;
                2'h1: decode_fmt = LMC_FMT_J1_ESF;
                default: decode_fmt = LMC_FMT_RESERVED;
            endcase
        end
    endfunction

    lmc_fmt_e fmt;
    logic e1;
    logic ami;

    always_comb begin
        fmt = decode_fmt(lnk.mode);
        e1 = (fmt == LMC_FMT_E1);
        ami = lnk.ctrl[`LMC_CTRL_AMI_BIT];
        lnk.fmt = fmt;
        lnk.reserved = (fmt == LMC_FMT_RESERVED);
        // Reserved code falls back to unframed so the framer never sees an undefined format
        lnk.unframed = lnk.ctrl[`LMC_CTRL_UNFR_BIT] || (fmt == LMC_FMT_RESERVED);
        lnk.int_term_en = !lnk.term[`LMC_TERM_EXT_BIT];
        lnk.term_sel = lnk.term[`LMC_TERM_EXT_BIT] ? 2'h0 : lnk.term[1:0];
        lnk.rx_code = ami ? LMC_CODE_AMI : (e1 ? LMC_CODE_HDB3 : LMC_CODE_B8ZS);
        // E1 transmit has no AMI choice here
        lnk.tx_code = e1 ? LMC_CODE_HDB3 : (ami ? LMC_CODE_AMI : LMC_CODE_B8ZS);
        lnk.bpv_en = lnk.ctrl[`LMC_CTRL_BPV_BIT] && ami && !e1;
        lnk.rate_conv = lnk.ctrl[`LMC_CTRL_RATE_BIT] && !e1;
        case (fmt)
            LMC_FMT_T1_ESF, LMC_FMT_J1_ESF, LMC_FMT_T1_DM, LMC_FMT_E1: lnk.hdlc_cnt = 2'h3;
            LMC_FMT_T1_SF, LMC_FMT_J1_SF, LMC_FMT_T1_SLC96: lnk.hdlc_cnt = 2'h2;
            default: lnk.hdlc_cnt = 2'h0;
        endcase
    end
endmodule
`default_nettype wire

// >>> lmc_link_mode_config_decode.sv
// Purpose: Per-link mode and termination register bank with decode for eight links
// Assumes: Parallel register port synchronous to CLK_SYS, one access per strobe cycle
// Notes:   Decoded outputs lag register writes by two enabled clocks
//
// Behaviour
// - Each of eight links keeps its own mode, independent of the others.
// - T1 family: format 00 SF, 01 ESF, 10 DM, 11 SLC-96.
// - J1 variant: format 00 SF, 01 ESF; no DM or SLC-96.
// - Carrier bit low means E1; variant and format are ignored.
// - Mode register sits at 0x020 in each link page, pages 0x100 apart.
// - Termination top bit low enables internal receive matching.
// - Internal codes: 000 75, 001 120, 010 100, 011 110 ohm.
// - Termination top bit high disables internal matching, low bits ignored.
// - Receive decoding uses B8ZS for JAPAN_VARIANT_SELECT, HDB3 for E1, or AMI.
// - Transmit encoding uses AMI or B8ZS for JAPAN_VARIANT_SELECT, HDB3 for E1.
// - Bipolar violation insertion allowed only under AMI coding.
// - HDLC links: three for ESF, DM, E1; two for SF, SLC-96.
// - JAPAN_VARIANT_SELECT system stream may be rate converted 1.544 to 2.048.
// - JAPAN_VARIANT_SELECT links group four per bus; E1 puts one group of four.
// - Receive framing can be bypassed in every carrier family.
// - Loss of signal, code violations and excess zeros are reported per link.
`timescale 1ns/10ps
`default_nettype none
`include "lmc_params.svh"
module lmc_link_mode_config_decode
    import lmc_pkg::*;
(
    // Clock, reset, enable
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic CE,
    // Register port
    input wire logic [10:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Line events, one bit per link
    input wire logic [7:0] LOS_IN,
    input wire logic [7:0] LCV_IN,
    input wire logic [7:0] EXZ_IN,
    // Decoded personality, packed per link
    output logic [23:0] FRAME_FMT,
    output logic [7:0] MODE_RESERVED,
    output logic [7:0] FRAMER_BYPASS,
    output logic [15:0] RX_LINE_CODE,
    output logic [15:0] TX_LINE_CODE,
    output logic [7:0] BPV_INSERT_EN,
    output logic [15:0] HDLC_LINKS,
    output logic [7:0] RATE_CONV_EN,
    output logic [7:0] BUS_MEMBER,
    output logic [7:0] INT_TERM_EN,
    output logic [15:0] TERM_SEL
);
    localparam int NL = `LMC_NUM_LINKS;

    function automatic logic hit(input logic [10:0] a, input logic [2:0] link, input logic [7:0] ofs);
        hit = (a[10:8] == link) && (a[7:0] == ofs);
    endfunction

    // ----------------------------------------------------------------
    // Per-link decoders
    // ----------------------------------------------------------------
    logic [7:0] mode_reg [NL];
    logic [7:0] ctrl_reg [NL];
    logic [7:0] term_reg [NL];
    logic [2:0] evt_reg [NL];
    logic [7:0] sys_reg;
    logic [7:0] rdata_reg;

    lmc_fmt_e d_fmt [NL];
    logic [NL-1:0] d_res, d_unfr, d_term_en, d_bpv, d_rate;
    logic [1:0] d_tsel [NL];
    logic [1:0] d_hdlc [NL];
    lmc_code_e d_rx [NL];
    lmc_code_e d_tx [NL];

    lmc_link_if lif [NL] ();

    genvar g;
    generate
        for (g = 0; g < NL; g++) begin : g_link
            assign lif[g].mode = mode_reg[g];
            assign lif[g].ctrl = ctrl_reg[g];
            assign lif[g].term = term_reg[g];
            lmc_mode_decode u_dec (
                .lnk(lif[g])
            );
            assign d_fmt[g] = lif[g].fmt;
            assign d_res[g] = lif[g].reserved;
            assign d_unfr[g] = lif[g].unframed;
            assign d_term_en[g] = lif[g].int_term_en;
            assign d_tsel[g] = lif[g].term_sel;
            assign d_rx[g] = lif[g].rx_code;
            assign d_tx[g] = lif[g].tx_code;
            assign d_bpv[g] = lif[g].bpv_en;
            assign d_rate[g] = lif[g].rate_conv;
            assign d_hdlc[g] = lif[g].hdlc_cnt;
        end
    endgenerate

    // ----------------------------------------------------------------
    // Register bank
    // ----------------------------------------------------------------
    logic [7:0] mode_next [NL];
    logic [7:0] ctrl_next [NL];
    logic [7:0] term_next [NL];
    logic [2:0] evt_next [NL];
    logic [7:0] sys_next;
    logic [7:0] rdata_next;

    always_comb begin
        sys_next = sys_reg;
        rdata_next = rdata_reg;
        if (CE && WR && hit(ADDR, 3'h0, `LMC_OFS_SYS)) begin
            sys_next = WDATA;
        end
        if (CE && RD) begin
            rdata_next = 8'h00;
            if (hit(ADDR, 3'h0, `LMC_OFS_SYS)) begin
                rdata_next = sys_reg;
            end
        end
        for (int i = 0; i < NL; i++) begin
            mode_next[i] = mode_reg[i];
            ctrl_next[i] = ctrl_reg[i];
            term_next[i] = term_reg[i];
            evt_next[i] = evt_reg[i];
            if (CE && WR && hit(ADDR, 3'(i), `LMC_OFS_MODE)) begin
                mode_next[i] = WDATA;
            end
            if (CE && WR && hit(ADDR, 3'(i), `LMC_OFS_CTRL)) begin
                ctrl_next[i] = WDATA;
            end
            if (CE && WR && hit(ADDR, 3'(i), `LMC_OFS_TERM)) begin
                term_next[i] = WDATA;
            end
            // Write one to clear; an event in the clearing cycle still lands
            if (CE && WR && hit(ADDR, 3'(i), `LMC_OFS_EVT)) begin
                evt_next[i] = evt_next[i] & ~WDATA[2:0];
            end
            if (CE) begin
                evt_next[i] = evt_next[i] | {EXZ_IN[i], LCV_IN[i], LOS_IN[i]};
            end
            if (CE && RD) begin
                if (hit(ADDR, 3'(i), `LMC_OFS_MODE)) begin
                    rdata_next = mode_reg[i];
                end else if (hit(ADDR, 3'(i), `LMC_OFS_CTRL)) begin
                    rdata_next = ctrl_reg[i];
                end else if (hit(ADDR, 3'(i), `LMC_OFS_TERM)) begin
                    rdata_next = term_reg[i];
                end else if (hit(ADDR, 3'(i), `LMC_OFS_EVT)) begin
                    rdata_next = {5'h00, evt_reg[i]};
                end
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            sys_reg <= `LMC_RST_SYS;
            rdata_reg <= 8'h00;
            for (int i = 0; i < NL; i++) begin
                mode_reg[i] <= `LMC_RST_MODE;
                ctrl_reg[i] <= `LMC_RST_CTRL;
                term_reg[i] <= `LMC_RST_TERM;
                evt_reg[i] <= `LMC_RST_EVT;
            end
        end else begin
            sys_reg <= sys_next;
            rdata_reg <= rdata_next;
            for (int i = 0; i < NL; i++) begin
                mode_reg[i] <= mode_next[i];
                ctrl_reg[i] <= ctrl_next[i];
                term_reg[i] <= term_next[i];
                evt_reg[i] <= evt_next[i];
            end
        end
    end

    assign RDATA = rdata_reg;

    // ----------------------------------------------------------------
    // Registered decoded outputs
    // ----------------------------------------------------------------
    logic [NL-1:0][2:0] fmt_reg, fmt_next;
    logic [NL-1:0][1:0] rx_reg, rx_next, tx_reg, tx_next, hdlc_reg, hdlc_next, tsel_reg, tsel_next;
    logic [NL-1:0] res_reg, res_next, unfr_reg, unfr_next, bpv_reg, bpv_next;
    logic [NL-1:0] rate_reg, rate_next, bus_reg, bus_next, tint_reg, tint_next;

    always_comb begin
        fmt_next = fmt_reg;
        rx_next = rx_reg;
        tx_next = tx_reg;
        hdlc_next = hdlc_reg;
        tsel_next = tsel_reg;
        res_next = res_reg;
        unfr_next = unfr_reg;
        bpv_next = bpv_reg;
        rate_next = rate_reg;
        bus_next = bus_reg;
        tint_next = tint_reg;
        if (CE) begin
            for (int i = 0; i < NL; i++) begin
                fmt_next[i] = d_fmt[i];
                rx_next[i] = d_rx[i];
                tx_next[i] = d_tx[i];
                hdlc_next[i] = d_hdlc[i];
                tsel_next[i] = d_tsel[i];
                res_next[i] = d_res[i];
                unfr_next[i] = d_unfr[i];
                bpv_next[i] = d_bpv[i];
                rate_next[i] = d_rate[i];
                tint_next[i] = d_term_en[i];
                // E1 has room for only one group of four on the shared bus
                bus_next[i] = ctrl_reg[i][`LMC_CTRL_MUX_BIT] && ((d_fmt[i] != LMC_FMT_E1) ||
                    ((i / 4) == int'(sys_reg[`LMC_SYS_E1GRP_BIT])));
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
            fmt_reg <= '0;
            rx_reg <= '0;
            tx_reg <= '0;
            hdlc_reg <= '0;
            tsel_reg <= '0;
            res_reg <= '0;
            unfr_reg <= '0;
            bpv_reg <= '0;
            rate_reg <= '0;
            bus_reg <= '0;
            tint_reg <= '0;
        end else begin
            fmt_reg <= fmt_next;
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            hdlc_reg <= hdlc_next;
            tsel_reg <= tsel_next;
            res_reg <= res_next;
            unfr_reg <= unfr_next;
            bpv_reg <= bpv_next;
            rate_reg <= rate_next;
            bus_reg <= bus_next;
            tint_reg <= tint_next;
        end
    end

    assign FRAME_FMT = fmt_reg;
    assign RX_LINE_CODE = rx_reg;
    assign TX_LINE_CODE = tx_reg;
    assign HDLC_LINKS = hdlc_reg;
    assign TERM_SEL = tsel_reg;
    assign MODE_RESERVED = res_reg;
    assign FRAMER_BYPASS = unfr_reg;
    assign BPV_INSERT_EN = bpv_reg;
    assign RATE_CONV_EN = rate_reg;
    assign BUS_MEMBER = bus_reg;
    assign INT_TERM_EN = tint_reg;

    // ----------------------------------------------------------------
    // Checks on link 0 and 1, covers on link 0 and 4
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    a_link_isolation: assert property (CE && WR && ADDR[10:8] == 3'h0 |=> $stable(mode_reg[1]))
        else $error("link 1 mode changed by link 0 write");
    a_t1_esf_decode: assert property (CE && mode_reg[0][3:0] == 4'h9 |=> FRAME_FMT[2:0] == 3'(LMC_FMT_T1_ESF))
        else $error("T1 ESF not decoded");
    a_j1_sf_decode: assert property (CE && mode_reg[0][3:0] == 4'hC |=> FRAME_FMT[2:0] == 3'(LMC_FMT_J1_SF))
        else $error("J1 SF not decoded");
    a_e1_ignore_rest: assert property (CE && !mode_reg[0][3] |=> FRAME_FMT[2:0] == 3'(LMC_FMT_E1))
        else $error("E1 not decoded");
    a_mode_readback: assert property (CE && WR && ADDR == 11'h120 ##1 CE && RD && ADDR == 11'h120
        |=> RDATA == $past(WDATA, 2))
        else $error("link 1 mode read back wrong");
    a_term_internal: assert property (CE && term_reg[0][2:0] == 3'h2 |=> INT_TERM_EN[0] && TERM_SEL[1:0] == 2'h2)
        else $error("internal 100 ohm not selected");
    a_term_external: assert property (CE && term_reg[0][2] |=> !INT_TERM_EN[0])
        else $error("internal matching left on");
    a_bpv_ami_only: assert property (BPV_INSERT_EN[0] |-> RX_LINE_CODE[1:0] == 2'(LMC_CODE_AMI))
        else $error("violation insertion without AMI");
    a_hdlc_count: assert property (CE && mode_reg[0][3:0] == 4'h8 |=> HDLC_LINKS[1:0] == 2'h2)
        else $error("SF HDLC count wrong");
    a_rate_not_e1: assert property (RATE_CONV_EN[0] |-> FRAME_FMT[2:0] != 3'(LMC_FMT_E1))
        else $error("rate conversion in E1");
    a_event_sticky: assert property (CE && LOS_IN[0] ##1 !(CE && WR && ADDR == 11'h038)
        |-> evt_reg[0][0] [*2])
        else $error("loss of signal not held");
    a_reserved_hold: assert property (CE && mode_reg[0][3:1] == 3'h7 |=> MODE_RESERVED[0] && FRAMER_BYPASS[0])
        else $error("reserved J1 code not held unframed");

    c_t1_dm: cover property (FRAME_FMT[2:0] == 3'(LMC_FMT_T1_DM));
    c_e1_bus: cover property (BUS_MEMBER[4] && FRAME_FMT[14:12] == 3'(LMC_FMT_E1));
    c_evt_clear: cover property (evt_reg[0] != 3'h0 ##1 evt_reg[0] == 3'h0);
endmodule
`default_nettype wire

// >>> lmc_testbench.sv
// Purpose: Self-checking bench for the eight-link mode bank and decode
// Assumes: Inputs change on the falling edge; CE held high except in one refusal case
// Notes:   Expected values come from the bit layout alone, never from DUT outputs
`timescale 1ns/10ps
`default_nettype none
`include "lmc_params.svh"
module testbench;
    import lmc_pkg::*;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic ce = 1'h1;
    logic [10:0] addr = 11'h000;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'h0;
    logic rd_s = 1'h0;
    logic [7:0] rdata;
    logic [7:0] los_in = 8'h00;
    logic [7:0] lcv_in = 8'h00;
    logic [7:0] exz_in = 8'h00;
    logic [23:0] frame_fmt;
    logic [7:0] mode_reserved, framer_bypass, bpv_insert_en, rate_conv_en, bus_member, int_term_en;
    logic [15:0] rx_line_code, tx_line_code, hdlc_links, term_sel;
    logic [7:0] d;
    int errors = 0;
    int check_count = 0;

    always #12.5 clk_sys = ~clk_sys;

    lmc_link_mode_config_decode dut (.CLK_SYS(clk_sys), .RST(rst), .CE(ce), .ADDR(addr), .WDATA(wdata),
        .WR(wr_s), .RD(rd_s), .RDATA(rdata), .LOS_IN(los_in), .LCV_IN(lcv_in), .EXZ_IN(exz_in),
        .FRAME_FMT(frame_fmt), .MODE_RESERVED(mode_reserved), .FRAMER_BYPASS(framer_bypass),
        .RX_LINE_CODE(rx_line_code), .TX_LINE_CODE(tx_line_code), .BPV_INSERT_EN(bpv_insert_en),
        .HDLC_LINKS(hdlc_links), .RATE_CONV_EN(rate_conv_en), .BUS_MEMBER(bus_member),
        .INT_TERM_EN(int_term_en), .TERM_SEL(term_sel));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic wrap_up;
        if (errors == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Called at a falling edge, returns at a falling edge
    task automatic wr(input logic [2:0] pg, input logic [7:0] ofs, input logic [7:0] v);
        addr = {pg, ofs};
        wdata = v;
        wr_s = 1'h1;
        @(negedge clk_sys);
        wr_s = 1'h0;
        // Idle cycle so a following call never reassigns the strobe in the same step
        @(negedge clk_sys);
    endtask

    task automatic rd(input logic [2:0] pg, input logic [7:0] ofs, output logic [7:0] v);
        addr = {pg, ofs};
        rd_s = 1'h1;
        @(negedge clk_sys);
        rd_s = 1'h0;
        @(negedge clk_sys);
        v = rdata;
    endtask

    // Outputs lag a write by two enabled edges; one spare
    task automatic settle;
        repeat (3) @(negedge clk_sys);
    endtask

    function automatic logic [2:0] fmt_of(input logic [3:0] m);
        if (!m[3]) return LMC_FMT_E1;
        if (!m[2]) return m[2:0];
        if (!m[1]) return m[0] ? LMC_FMT_J1_ESF : LMC_FMT_J1_SF;
        return LMC_FMT_RESERVED;
    endfunction

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        @(negedge clk_sys);
        chk({5'h00, frame_fmt[2:0]}, 8'h00, "fmt in reset");
        rst = 1'h0;
        settle();
        for (int n = 0; n < 8; n++) begin
            chk({5'h00, frame_fmt[3*n+:3]}, {5'h00, 3'(LMC_FMT_E1)}, "reset fmt");
            rd(3'(n), `LMC_OFS_MODE, d);
            chk(d, `LMC_RST_MODE, "reset mode");
        end
    endtask

    task automatic t_modes;
        logic [2:0] f;
        logic [1:0] h;
        logic [1:0] lc;
        for (int m = 0; m < 16; m++) begin
            f = fmt_of(4'(m));
            h = (f == LMC_FMT_RESERVED) ? 2'h0 : (f == LMC_FMT_T1_SF || f == LMC_FMT_T1_SLC96 ||
                f == LMC_FMT_J1_SF) ? 2'h2 : 2'h3;
            lc = (f == LMC_FMT_E1) ? LMC_CODE_HDB3 : LMC_CODE_B8ZS;
            wr(3'h1, `LMC_OFS_MODE, {4'hA, 4'(m)});
            settle();
            chk({5'h00, frame_fmt[5:3]}, {5'h00, f}, "format");
            chk({6'h00, hdlc_links[3:2]}, {6'h00, h}, "hdlc");
            chk({6'h00, mode_reserved[1], framer_bypass[1]}, {6'h00, {2{f == LMC_FMT_RESERVED}}}, "rsv");
            chk({4'h0, rx_line_code[3:2], tx_line_code[3:2]}, {4'h0, lc, lc}, "codes");
            rd(3'h1, `LMC_OFS_MODE, d);
            chk(d, {4'hA, 4'(m)}, "readback");
        end
    endtask

    task automatic t_indep;
        for (int n = 0; n < 8; n++) begin
            wr(3'(n), `LMC_OFS_MODE, {4'(n), 2'h2, 2'(n)});
        end
        settle();
        for (int n = 0; n < 8; n++) begin
            chk({5'h00, frame_fmt[3*n+:3]}, {6'h00, 2'(n)}, "per link fmt");
            rd(3'(n), `LMC_OFS_MODE, d);
            chk(d, {4'(n), 2'h2, 2'(n)}, "per link readback");
        end
    endtask

    task automatic t_term;
        for (int c = 0; c < 8; c++) begin
            wr(3'h2, `LMC_OFS_TERM, 8'(c));
            settle();
            chk({7'h00, int_term_en[2]}, {7'h00, ~c[2]}, "int term");
            chk({6'h00, term_sel[5:4]}, {6'h00, c[2] ? 2'h0 : 2'(c)}, "term sel");
        end
    endtask

    // e = {bus, bypass, rate, bpv, tx code, rx code} for link 3
    task automatic ctl(input logic [7:0] m, input logic [7:0] c, input logic [7:0] e);
        wr(3'h3, `LMC_OFS_MODE, m);
        wr(3'h3, `LMC_OFS_CTRL, c);
        settle();
        chk({bus_member[3], framer_bypass[3], rate_conv_en[3], bpv_insert_en[3], tx_line_code[7:6],
            rx_line_code[7:6]}, e, "ctrl decode");
    endtask

    task automatic t_ctrl;
        wr(3'h0, `LMC_OFS_SYS, 8'h00);
        ctl(8'h08, 8'h03, {4'h1, LMC_CODE_AMI, LMC_CODE_AMI});
        ctl(8'h00, 8'h03, {4'h0, LMC_CODE_HDB3, LMC_CODE_AMI});
        ctl(8'h09, 8'h02, {4'h0, LMC_CODE_B8ZS, LMC_CODE_B8ZS});
        ctl(8'h0D, 8'h08, {4'h2, LMC_CODE_B8ZS, LMC_CODE_B8ZS});
        ctl(8'h00, 8'h08, {4'h0, LMC_CODE_HDB3, LMC_CODE_HDB3});
        ctl(8'h00, 8'h04, {4'h4, LMC_CODE_HDB3, LMC_CODE_HDB3});
        ctl(8'h0C, 8'h04, {4'h4, LMC_CODE_B8ZS, LMC_CODE_B8ZS});
        ctl(8'h0B, 8'h14, {4'hC, LMC_CODE_B8ZS, LMC_CODE_B8ZS});
        ctl(8'h00, 8'h10, {4'h8, LMC_CODE_HDB3, LMC_CODE_HDB3});
        wr(3'h0, `LMC_OFS_SYS, 8'h01);
        ctl(8'h00, 8'h10, {4'h0, LMC_CODE_HDB3, LMC_CODE_HDB3});
    endtask

    task automatic t_events;
        for (int b = 0; b < 3; b++) begin
            los_in[5] = (b == 0);
            lcv_in[5] = (b == 1);
            exz_in[5] = (b == 2);
            @(negedge clk_sys);
            los_in = 8'h00;
            lcv_in = 8'h00;
            exz_in = 8'h00;
            rd(3'h5, `LMC_OFS_EVT, d);
            chk(d, 8'(1 << b), "event set");
            rd(3'h4, `LMC_OFS_EVT, d);
            chk(d, 8'h00, "other link event");
            wr(3'h5, `LMC_OFS_EVT, 8'(1 << b));
            rd(3'h5, `LMC_OFS_EVT, d);
            chk(d, 8'h00, "event cleared");
        end
    endtask

    // Unmapped offset and strobes with CE low must leave state alone
    task automatic t_refuse;
        wr(3'h0, `LMC_OFS_MODE, 8'h09);
        wr(3'h0, 8'hFF, 8'h5A);
        rd(3'h0, 8'hFF, d);
        chk(d, 8'h00, "unmapped read");
        ce = 1'h0;
        wr(3'h0, `LMC_OFS_MODE, 8'h0F);
        ce = 1'h1;
        rd(3'h0, `LMC_OFS_MODE, d);
        chk(d, 8'h09, "ce low write");
        settle();
        chk({5'h00, frame_fmt[2:0]}, {5'h00, 3'(LMC_FMT_T1_ESF)}, "ce low fmt");
    endtask

    // ----------------------------------------------------------------
    // Main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        t_reset();
        t_modes();
        t_indep();
        t_term();
        t_ctrl();
        t_events();
        t_refuse();
        wrap_up();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        errors++;
        $display("mismatch %0t run did not finish", $time);
        wrap_up();
    end
endmodule
`default_nettype wire
